// ### timer16.sv
`timescale 1ns/100ps
module timer16 (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pins and system
    input wire logic external_count_input,
    input wire logic sleep_mode,
    input wire logic ccp_special_trigger,
    output logic crystal_osc_on,
    output logic crystal_pins_force_in,
    output logic count_overflow_irq,
    output logic wake_request,
    output logic capture_base_valid
);
    import timer16_pkg::*;

    // ****************************************
    // Registers
    // ****************************************
    logic [7:0] ctrl_ff;
    logic [15:0] count_ff;
    logic overflow_flag_ff;
    logic overflow_irq_enable_ff;
    logic [1:0] insn_div_ff;
    logic [2:0] pre_ff;
    logic ext_s1_ff;
    logic ext_s2_ff;
    logic ext_prev_ff;
    logic [31:0] nxt_prdata;

    logic count_run;
    logic clock_source_select;
    logic sync_bypass_n;
    logic crystal_osc_enable;
    div_sel_t input_divide_select;
    logic wr_en;
    logic rd_en;
    logic addr_ok;
    logic ext_rise;
    logic src_tick;
    logic pre_tick;
    logic inc_en;
    logic wr_cnt;
    logic wrap;

    assign count_run = ctrl_ff[RUN_BIT];
    assign clock_source_select = ctrl_ff[SRC_BIT];
    assign sync_bypass_n = ctrl_ff[SYNCN_BIT];
    assign crystal_osc_enable = ctrl_ff[OSC_BIT];
    assign input_divide_select = div_sel_t'(ctrl_ff[DIV_HI:DIV_LO]);

    // Bus strobes, zero wait states
    assign wr_en = psel && penable && pwrite && clk_en;
    assign rd_en = psel && !penable && !pwrite && clk_en;
    assign pready = 1'b1;
    assign addr_ok = (paddr == CTRL_OFFSET) || (paddr == CNT_LOW_OFFSET)
        || (paddr == CNT_HIGH_OFFSET) || (paddr == FLAG_OFFSET)
        || (paddr == IRQ_EN_OFFSET) || (paddr == STATUS_OFFSET);
    assign pslverr = psel && penable && !addr_ok;

    // ****************************************
    // Control and enable registers
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= CTRL_RESET;
        end else if (wr_en && paddr == CTRL_OFFSET) begin
            ctrl_ff <= pwdata[7:0] & CTRL_MASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overflow_irq_enable_ff <= 1'b0;
        end else if (wr_en && paddr == IRQ_EN_OFFSET) begin
            overflow_irq_enable_ff <= pwdata[0];
        end
    end

    // Oscillator power and pin direction override
    assign crystal_osc_on = crystal_osc_enable;
    assign crystal_pins_force_in = crystal_osc_enable;

    // ****************************************
    // External pin synchroniser and edge detect
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_s1_ff <= 1'b0;
            ext_s2_ff <= 1'b0;
            ext_prev_ff <= 1'b0;
        end else if (clk_en) begin
            ext_s1_ff <= external_count_input;
            ext_s2_ff <= ext_s1_ff;
            ext_prev_ff <= ext_s2_ff;
        end
    end
    // Synced and unsynced modes use the same synchroniser stages here
    assign ext_rise = ext_s2_ff && !ext_prev_ff;

    // Instruction cycle divider
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            insn_div_ff <= 2'b00;
        end else if (clk_en) begin
            insn_div_ff <= insn_div_ff + 2'b01;
        end
    end

    // Source select: timer or counter
    assign src_tick = clock_source_select ? ext_rise
                                          : (insn_div_ff == INSN_DIV_LAST);

    // ****************************************
    // Input prescaler
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_ff <= 3'b000;
        end else if (clk_en && (wr_en && paddr == CTRL_OFFSET)) begin
            pre_ff <= 3'b000;
        end else if (clk_en && src_tick && count_run) begin
            pre_ff <= pre_ff + 3'b001;
        end
    end

    always_comb begin
        case (input_divide_select)
            DIV_1: pre_tick = src_tick;
            DIV_2: pre_tick = src_tick && (pre_ff[0] == 1'b1);
            DIV_4: pre_tick = src_tick && (pre_ff[1:0] == 2'b11);
            DIV_8: pre_tick = src_tick && (pre_ff == 3'b111);
            default: pre_tick = 1'b0;
        endcase
    end

    assign inc_en = clk_en && count_run && pre_tick;
    assign wr_cnt = wr_en && (paddr == CNT_LOW_OFFSET || paddr == CNT_HIGH_OFFSET);
    assign wrap = inc_en && !wr_cnt && (count_ff == COUNT_MAX);

    // ****************************************
    // Count pair
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_ff <= COUNT_RESET;
        end else if (wr_en && paddr == CNT_LOW_OFFSET) begin
            count_ff[7:0] <= pwdata[7:0];
        end else if (wr_en && paddr == CNT_HIGH_OFFSET) begin
            count_ff[15:8] <= pwdata[7:0];
        end else if (clk_en && ccp_special_trigger) begin
            count_ff <= COUNT_RESET;
        end else if (inc_en) begin
            count_ff <= count_ff + 16'h0001;
        end
    end

    // Sticky overflow flag, set beats clear, trigger reset excluded
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overflow_flag_ff <= 1'b0;
        end else if (clk_en) begin
            if (wrap && !ccp_special_trigger) begin
                overflow_flag_ff <= 1'b1;
            end else if (wr_en && paddr == FLAG_OFFSET && pwdata[0]) begin
                overflow_flag_ff <= 1'b0;
            end
        end
    end

    assign count_overflow_irq = overflow_flag_ff && overflow_irq_enable_ff;
    // Sleep wake only from unsynced counter mode
    assign wake_request = sleep_mode && overflow_flag_ff && overflow_irq_enable_ff
        && clock_source_select && sync_bypass_n;
    assign capture_base_valid = !(clock_source_select && sync_bypass_n);

    // ****************************************
    // Read data, captured in setup phase
    // ****************************************
    always_comb begin
        nxt_prdata = 32'h0000_0000;
        case (paddr)
            CTRL_OFFSET: nxt_prdata = {24'h00_0000, ctrl_ff};
            CNT_LOW_OFFSET: nxt_prdata = {24'h00_0000, count_ff[7:0]};
            CNT_HIGH_OFFSET: nxt_prdata = {24'h00_0000, count_ff[15:8]};
            FLAG_OFFSET: nxt_prdata = {31'h0000_0000, overflow_flag_ff};
            IRQ_EN_OFFSET: nxt_prdata = {31'h0000_0000, overflow_irq_enable_ff};
            STATUS_OFFSET: nxt_prdata = {30'h0000_0000, capture_base_valid, count_run};
            default: nxt_prdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en) begin
            prdata <= nxt_prdata;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    a_wrap_flag: assert property (@(posedge pclk) disable iff (!presetn)
        wrap && !ccp_special_trigger |=> overflow_flag_ff && count_ff == COUNT_RESET)
        else $error("wrap did not set flag");
    a_stop_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !count_run && !wr_cnt && !ccp_special_trigger |=> $stable(count_ff))
        else $error("stopped counter moved");
    a_trig_clear: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && ccp_special_trigger && !wr_cnt |=> count_ff == COUNT_RESET)
        else $error("trigger did not clear");
    a_trig_noflag: assert property (@(posedge pclk) disable iff (!presetn)
        ccp_special_trigger && !overflow_flag_ff |=> !overflow_flag_ff)
        else $error("trigger set flag");
    a_write_wins: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && paddr == CNT_LOW_OFFSET |=> count_ff[7:0] == $past(pwdata[7:0]))
        else $error("write lost");
    a_ctrl_top: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_ff[7:6] == 2'b00)
        else $error("reserved bits set");
    a_timer_rate: assert property (@(posedge pclk) disable iff (!presetn)
        inc_en && !clock_source_select |=> !inc_en [*3])
        else $error("timer faster than instruction cycle");
    a_div_two: assert property (@(posedge pclk) disable iff (!presetn)
        inc_en && input_divide_select == DIV_2 && !wr_en && !clock_source_select
        |=> !inc_en [*7])
        else $error("divide by two too fast");
    a_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
        count_overflow_irq |-> overflow_irq_enable_ff)
        else $error("irq without enable");
    a_pins_in: assert property (@(posedge pclk) disable iff (!presetn)
        crystal_osc_enable |-> crystal_pins_force_in)
        else $error("pins not forced");
    a_enable_freeze: assert property (@(posedge pclk) disable iff (!presetn)
        !clk_en |=> $stable(count_ff) && $stable(ctrl_ff) && $stable(prdata))
        else $error("state moved while clock enable low");
    a_high_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && paddr == CNT_HIGH_OFFSET |=> count_ff[15:8] == $past(pwdata[7:0]))
        else $error("high byte write lost");
    a_count_step: assert property (@(posedge pclk) disable iff (!presetn)
        inc_en && !wr_cnt && !ccp_special_trigger |=> count_ff == $past(count_ff) + 16'h0001)
        else $error("count did not step by one");
    a_ext_edge: assert property (@(posedge pclk) disable iff (!presetn)
        inc_en && clock_source_select |-> ext_rise)
        else $error("counter moved without pin edge");
    a_int_tick: assert property (@(posedge pclk) disable iff (!presetn)
        inc_en && !clock_source_select |-> insn_div_ff == INSN_DIV_LAST)
        else $error("timer moved off instruction cycle");
    a_base_async: assert property (@(posedge pclk) disable iff (!presetn)
        clock_source_select && sync_bypass_n |-> !capture_base_valid)
        else $error("unsynced counter offered as base");
    a_wake_mode: assert property (@(posedge pclk) disable iff (!presetn)
        wake_request |-> sleep_mode && clock_source_select && sync_bypass_n)
        else $error("wake outside unsynced sleep");
    a_ctrl_read: assert property (@(posedge pclk) disable iff (!presetn)
        rd_en && paddr == CTRL_OFFSET |=> prdata[7:6] == 2'b00)
        else $error("reserved control bits read set");
    a_flag_hold: assert property (@(posedge pclk) disable iff (!presetn)
        overflow_flag_ff && !(wr_en && paddr == FLAG_OFFSET) |=> overflow_flag_ff)
        else $error("flag dropped without clear");
    a_flag_clear: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && paddr == FLAG_OFFSET && pwdata[0] && !wrap |=> !overflow_flag_ff)
        else $error("flag clear ignored");
    // Cover points for the main scenarios
    c_overflow: cover property (@(posedge pclk) wrap);
    c_ext_count: cover property (@(posedge pclk) inc_en && clock_source_select);
    c_trigger: cover property (@(posedge pclk) ccp_special_trigger && count_run);
    c_wake: cover property (@(posedge pclk) wake_request);
    c_div_eight: cover property (@(posedge pclk) inc_en && input_divide_select == DIV_8);

endmodule : timer16

// ### timer16_pkg.sv
package timer16_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] CTRL_OFFSET = 8'h10;
    localparam logic [7:0] CNT_LOW_OFFSET = 8'h14;
    localparam logic [7:0] CNT_HIGH_OFFSET = 8'h18;
    localparam logic [7:0] FLAG_OFFSET = 8'h1C;
    localparam logic [7:0] IRQ_EN_OFFSET = 8'h20;
    localparam logic [7:0] STATUS_OFFSET = 8'h24;

    // ****************************************
    // Control field positions and reset values
    // ****************************************
    localparam int RUN_BIT = 0;
    localparam int SRC_BIT = 1;
    localparam int SYNCN_BIT = 2;
    localparam int OSC_BIT = 3;
    localparam int DIV_LO = 4;
    localparam int DIV_HI = 5;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] CTRL_MASK = 8'h3F;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;

    // ****************************************
    // Timing: instruction cycle is four oscillator periods
    // ****************************************
    localparam logic [1:0] INSN_DIV_LAST = 2'h3;

    typedef enum logic [1:0] {
        DIV_1 = 2'b00,
        DIV_2 = 2'b01,
        DIV_4 = 2'b10,
        DIV_8 = 2'b11
    } div_sel_t;

endpackage : timer16_pkg

// ### ext_clk_src.sv
`timescale 1ns/100ps
module ext_clk_src (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Burst control and count pin
    input wire logic gen,
    output logic pin_ff
);
    // ********
    // Count pin source
    // ********
    logic [6:0] ph_ff;

    // One rising edge per eight pclk periods; pin sits low between bursts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ph_ff <= 7'h00;
            pin_ff <= 1'h0;
        end else if (!gen) begin
            ph_ff <= 7'h00;
            pin_ff <= 1'h0;
        end else begin
            ph_ff <= ph_ff + 7'h01;
            pin_ff <= ph_ff[2];
        end
    end
endmodule : ext_clk_src

// ### sixteen_bit_timer_counter_bench.sv
`timescale 1ns/100ps
module sixteen_bit_timer_counter_bench;
    import timer16_pkg::*;
    // ********
    // Signals and instances
    // ********
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic sleep_mode, trig, gen, ext_pin, osc_on, force_in, irq, wake, base_ok, clk_en;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    int mismatches, compares;

    timer16 timer16_i (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .external_count_input(ext_pin), .sleep_mode(sleep_mode),
        .ccp_special_trigger(trig), .crystal_osc_on(osc_on),
        .crystal_pins_force_in(force_in), .count_overflow_irq(irq),
        .wake_request(wake), .capture_base_valid(base_ok));
    ext_clk_src ext_clk_src_i (.pclk(pclk), .presetn(presetn), .gen(gen), .pin_ff(ext_pin));

    // Free-running 25 MHz clock
    initial begin
        pclk = 1'h0;
        forever #20 pclk = ~pclk;
    end

    // Verdict and end of run
    task automatic complete_run();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : complete_run

    // Compare one byte against its expected value
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // Wait a fixed number of edges
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask : tick

    // One APB transfer, held until pready is seen high
    task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
        int n;
        n = 0;
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 64);
        q = prdata;
        err = pslverr;
        if (n >= 64) begin
            mismatches++;
            complete_run();
        end
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask : xfer

    // Control reset, reserved bits, unmapped place, stopped count bytes
    task automatic t_regs();
        xfer(CTRL_OFFSET, 1'h0, 8'h00);
        chk("ctrl_reset", q[7:0], 8'h00);
        xfer(CTRL_OFFSET, 1'h1, 8'hF0);
        xfer(CTRL_OFFSET, 1'h0, 8'h00);
        chk("ctrl_reserved", q[7:0], 8'h30);
        xfer(8'h40, 1'h0, 8'h00);
        chk("unmapped_err", {7'h00, err}, 8'h01);
        xfer(CNT_LOW_OFFSET, 1'h1, 8'hA5);
        xfer(CNT_HIGH_OFFSET, 1'h1, 8'h3C);
        tick(20);
        xfer(CNT_LOW_OFFSET, 1'h0, 8'h00);
        chk("count_low", q[7:0], 8'hA5);
        xfer(CNT_HIGH_OFFSET, 1'h0, 8'h00);
        chk("count_high", q[7:0], 8'h3C);
    endtask : t_regs

    // Every divide code in timer mode, then a wrap with flag and request
    task automatic t_timer();
        logic [7:0] e;
        for (int c = 0; c < 4; c++) begin
            xfer(CNT_LOW_OFFSET, 1'h1, 8'h00);
            xfer(CTRL_OFFSET, 1'h1, {2'h0, c[1:0], 4'h1});
            tick(254);
            xfer(CTRL_OFFSET, 1'h1, 8'h00);
            xfer(CNT_LOW_OFFSET, 1'h0, 8'h00);
            e = 8'h40 >> c;
            chk("div_ticks", {7'h00, q[7:0] >= e - 8'h01 && q[7:0] <= e + 8'h01}, 8'h01);
        end
        xfer(CNT_LOW_OFFSET, 1'h1, 8'hFE);
        xfer(CNT_HIGH_OFFSET, 1'h1, 8'hFF);
        xfer(CTRL_OFFSET, 1'h1, 8'h01);
        tick(20);
        xfer(CTRL_OFFSET, 1'h1, 8'h00);
        xfer(CNT_HIGH_OFFSET, 1'h0, 8'h00);
        chk("wrap_high", q[7:0], 8'h00);
        xfer(FLAG_OFFSET, 1'h0, 8'h00);
        chk("flag_set", q[7:0], 8'h01);
        chk("irq_masked", {7'h00, irq}, 8'h00);
        xfer(IRQ_EN_OFFSET, 1'h1, 8'h01);
        chk("irq_on", {7'h00, irq}, 8'h01);
        xfer(FLAG_OFFSET, 1'h1, 8'h01);
        chk("irq_cleared", {7'h00, irq}, 8'h00);
    endtask : t_timer

    // Synced pin counting, then unsynced wrap in sleep
    task automatic t_counter();
        xfer(CNT_LOW_OFFSET, 1'h1, 8'h00);
        xfer(CNT_HIGH_OFFSET, 1'h1, 8'h00);
        xfer(CTRL_OFFSET, 1'h1, 8'h03);
        chk("base_synced", {7'h00, base_ok}, 8'h01);
        gen <= 1'h1;
        tick(80);
        gen <= 1'h0;
        tick(10);
        xfer(CTRL_OFFSET, 1'h1, 8'h00);
        xfer(CNT_LOW_OFFSET, 1'h0, 8'h00);
        chk("pin_edges", q[7:0], 8'h0A);
        xfer(CNT_LOW_OFFSET, 1'h1, 8'hFF);
        xfer(CNT_HIGH_OFFSET, 1'h1, 8'hFF);
        xfer(CTRL_OFFSET, 1'h1, 8'h07);
        chk("base_unsynced", {7'h00, base_ok}, 8'h00);
        xfer(STATUS_OFFSET, 1'h0, 8'h00);
        chk("status", q[7:0], 8'h01);
        sleep_mode <= 1'h1;
        gen <= 1'h1;
        tick(8);
        gen <= 1'h0;
        tick(10);
        chk("wake", {7'h00, wake}, 8'h01);
        sleep_mode <= 1'h0;
        xfer(CTRL_OFFSET, 1'h1, 8'h00);
        xfer(FLAG_OFFSET, 1'h1, 8'h01);
    endtask : t_counter

    // Crystal enable, trigger clear, and a write meeting a trigger
    task automatic t_osc_trig();
        xfer(CTRL_OFFSET, 1'h1, 8'h08);
        tick(16);
        chk("osc_on", {7'h00, osc_on}, 8'h01);
        chk("pins_in", {7'h00, force_in}, 8'h01);
        xfer(CTRL_OFFSET, 1'h1, 8'h00);
        chk("osc_off", {7'h00, osc_on}, 8'h00);
        chk("pins_free", {7'h00, force_in}, 8'h00);
        xfer(CNT_LOW_OFFSET, 1'h1, 8'h77);
        trig <= 1'h1;
        tick(1);
        trig <= 1'h0;
        tick(1);
        xfer(CNT_LOW_OFFSET, 1'h0, 8'h00);
        chk("trig_clear", q[7:0], 8'h00);
        xfer(FLAG_OFFSET, 1'h0, 8'h00);
        chk("trig_no_flag", q[7:0], 8'h00);
        fork
            xfer(CNT_LOW_OFFSET, 1'h1, 8'h5A);
            begin
                @(posedge pclk);
                trig <= 1'h1;
                @(posedge pclk);
                trig <= 1'h0;
            end
        join
        xfer(CNT_LOW_OFFSET, 1'h0, 8'h00);
        chk("write_wins", q[7:0], 8'h5A);
        clk_en <= 1'h0;
        xfer(CNT_LOW_OFFSET, 1'h1, 8'h99);
        clk_en <= 1'h1;
        xfer(CNT_LOW_OFFSET, 1'h0, 8'h00);
        chk("frozen_write", q[7:0], 8'h5A);
    endtask : t_osc_trig

    // Reset, then each scenario in turn
    initial begin
        {psel, penable, pwrite, sleep_mode, trig, gen, presetn} = 7'h00;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        clk_en = 1'h1;
        mismatches = 0;
        compares = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        t_regs();
        t_timer();
        t_counter();
        t_osc_trig();
        complete_run();
    end
endmodule : sixteen_bit_timer_counter_bench
